// ### design/wcc_pkg.sv
// Constants and types for the wetting current configuration bank.
// Assumes one 20 MHz clock and a 32-bit AXI4-Lite register port.
//
// Contract
// - Four 3-bit pair selectors, readable and writable.
// - Codes 1..4 give 1,2,5,10 mA; 5..7 give 15.
// - Code zero turns pair off; selectors reset zero.
// - On-time field is (code+1) times 64 us.
// - Config bit 3 picks 15 mA for inputs 18-23.
// - Config bit 2 picks 15 mA for inputs 12-17.
// - Config bit 1 picks 15 mA for inputs 6-11.
// - Config bit 0 picks 15 mA for inputs 0-5.
// - One pulse enable bit per input, reset clear.
// - Config bits 23 to 7 read as zero.
package wcc_pkg;
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam int          STRB_W      = 4;
   // Printed offsets are word indices; the byte address is four times.
   localparam logic [5:0]  IDX_SEL     = 6'h1e;
   localparam logic [5:0]  IDX_CFG     = 6'h1f;
   localparam logic [5:0]  IDX_EN      = 6'h20;
   localparam int          NUM_PAIRS   = 4;
   localparam int          PAIR_W      = 3;
   localparam int          SEL_W       = 12;
   localparam int          CFG_W       = 7;
   localparam int          TIME_LSB    = 4;
   localparam int          TIME_W      = 3;
   localparam int          NUM_GRPS    = 4;
   localparam int          GRP_SIZE    = 6;
   localparam int          NUM_INPUTS  = 24;
   localparam logic [11:0] SEL_RST     = 12'h000;
   localparam logic [6:0]  CFG_RST     = 7'h00;
   localparam logic [23:0] EN_RST      = 24'h000000;
   localparam logic [2:0]  CODE_OFF    = 3'h0;
   localparam logic [2:0]  CODE_1MA    = 3'h1;
   localparam logic [2:0]  CODE_2MA    = 3'h2;
   localparam logic [2:0]  CODE_5MA    = 3'h3;
   localparam logic [2:0]  CODE_10MA   = 3'h4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam int          PULSE_UNIT_US  = 64;
   localparam int          CLK_MHZ        = 20;
   localparam int          PULSE_UNIT_CYC = PULSE_UNIT_US * CLK_MHZ;
   localparam int          CNT_W          = 16;

   typedef enum logic [2:0] {
      CUR_OFF, CUR_1MA, CUR_2MA, CUR_5MA, CUR_10MA, CUR_15MA
   } wcc_current_t;

   typedef enum logic {P_IDLE, P_ON} wcc_pulse_state_t;
endpackage : wcc_pkg

// ### design/wcc_pair_decode.sv
// Decoder from a 3-bit pair selector code to a wetting current level.
// Assumes the caller registers the result before it leaves the block.
module wcc_pair_decode
   import wcc_pkg::*;
(
   input  wire logic [2:0]   code,
   output wcc_current_t      level
);
   always_comb begin
      case (code)
         CODE_OFF:  level = CUR_OFF;
         CODE_1MA:  level = CUR_1MA;
         CODE_2MA:  level = CUR_2MA;
         CODE_5MA:  level = CUR_5MA;
         CODE_10MA: level = CUR_10MA;
         default:   level = CUR_15MA;
      endcase
   end
endmodule : wcc_pair_decode

// ### design/wcc_top.sv
// Wetting current configuration bank with AXI4-Lite register access.
// Assumes a pulse sequencer on ref_clk strobes pulse_start once per poll.
module wcc_top
   import wcc_pkg::*;
#(
   parameter int PULSE_UNIT_CYC_P = PULSE_UNIT_CYC
)(
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   input  wire logic [DATA_W-1:0]     s_axi_wdata,
   input  wire logic [STRB_W-1:0]     s_axi_wstrb,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output      logic [1:0]            s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output      logic [DATA_W-1:0]     s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   input  wire logic                  pulse_start,
   output      logic                  pulse_busy,
   output      logic                  pulse_done,
   output      logic [NUM_INPUTS-1:0] pulse_drive,
   output      wcc_current_t          pulse_level [NUM_GRPS],
   output      wcc_current_t          pair_level  [NUM_PAIRS]
);

   // Byte-lane merge of a write into the old word.
   function automatic logic [DATA_W-1:0] wcc_merge(
      input logic [DATA_W-1:0] old_word,
      input logic [DATA_W-1:0] new_word,
      input logic [STRB_W-1:0] strb
   );
      logic [DATA_W-1:0] res;
      res = old_word;
      for (int b = 0; b < STRB_W; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_word[b*8 +: 8];
         end
      end
      return res;
   endfunction : wcc_merge

   logic                  aw_hold_ff, nxt_aw_hold;
   logic [ADDR_W-1:0]     awaddr_ff, nxt_awaddr;
   logic                  w_hold_ff, nxt_w_hold;
   logic [DATA_W-1:0]     wdata_ff, nxt_wdata;
   logic [STRB_W-1:0]     wstrb_ff, nxt_wstrb;
   logic                  bvalid_ff, nxt_bvalid;
   logic [1:0]            bresp_ff, nxt_bresp;
   logic                  rvalid_ff, nxt_rvalid;
   logic [DATA_W-1:0]     rdata_ff, nxt_rdata;
   logic [1:0]            rresp_ff, nxt_rresp;
   logic [SEL_W-1:0]      sel_ff, nxt_sel;
   logic [CFG_W-1:0]      cfg_ff, nxt_cfg;
   logic [NUM_INPUTS-1:0] en_ff, nxt_en;
   logic                  wr_go;
   logic [5:0]            wr_idx, rd_idx;
   logic [DATA_W-1:0]     sel_word, cfg_word, en_word, merged;

   assign s_axi_awready = !aw_hold_ff;
   assign s_axi_wready  = !w_hold_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // A new write is committed only after the previous response is gone.
   assign wr_go  = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_idx = awaddr_ff[7:2];
   assign rd_idx = s_axi_araddr[7:2];

   // Unimplemented positions, config bits 23..7 among them, read zero.
   assign sel_word = {{(DATA_W-SEL_W){1'b0}}, sel_ff};
   assign cfg_word = {{(DATA_W-CFG_W){1'b0}}, cfg_ff};
   assign en_word  = {{(DATA_W-NUM_INPUTS){1'b0}}, en_ff};

   always_comb begin
      nxt_aw_hold = aw_hold_ff;
      nxt_awaddr  = awaddr_ff;
      nxt_w_hold  = w_hold_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_sel     = sel_ff;
      nxt_cfg     = cfg_ff;
      nxt_en      = en_ff;
      merged      = '0;
      if (s_axi_awvalid && !aw_hold_ff) begin
         nxt_aw_hold = 1'b1;
         nxt_awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_ff) begin
         nxt_w_hold = 1'b1;
         nxt_wdata  = s_axi_wdata;
         nxt_wstrb  = s_axi_wstrb;
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (wr_go) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = RESP_OKAY;
         case (wr_idx)
            IDX_SEL: begin
               merged  = wcc_merge(sel_word, wdata_ff, wstrb_ff);
               nxt_sel = merged[SEL_W-1:0];
            end
            IDX_CFG: begin
               merged  = wcc_merge(cfg_word, wdata_ff, wstrb_ff);
               nxt_cfg = merged[CFG_W-1:0];
            end
            IDX_EN: begin
               merged = wcc_merge(en_word, wdata_ff, wstrb_ff);
               nxt_en = merged[NUM_INPUTS-1:0];
            end
            default: begin
               nxt_bresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata  = rdata_ff;
      nxt_rresp  = rresp_ff;
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = RESP_OKAY;
         case (rd_idx)
            IDX_SEL: nxt_rdata = sel_word;
            IDX_CFG: nxt_rdata = cfg_word;
            IDX_EN:  nxt_rdata = en_word;
            default: begin
               nxt_rdata = '0;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         aw_hold_ff <= 1'b0;
         awaddr_ff  <= '0;
         w_hold_ff  <= 1'b0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
         sel_ff     <= SEL_RST;
         cfg_ff     <= CFG_RST;
         en_ff      <= EN_RST;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         awaddr_ff  <= nxt_awaddr;
         w_hold_ff  <= nxt_w_hold;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
         sel_ff     <= nxt_sel;
         cfg_ff     <= nxt_cfg;
         en_ff      <= nxt_en;
      end
   end

   // Current levels: pair selectors and pulse groups.
   wcc_current_t dec_level    [NUM_PAIRS];
   wcc_current_t pair_lvl_ff  [NUM_PAIRS];
   wcc_current_t pulse_lvl_ff [NUM_GRPS];

   for (genvar k = 0; k < NUM_PAIRS; k++) begin : g_pair
      wcc_pair_decode u_dec (
         .code  (sel_ff[k*PAIR_W +: PAIR_W]),
         .level (dec_level[k])
      );
      always_ff @(posedge ref_clk) begin
         if (!rstn) begin
            pair_lvl_ff[k] <= CUR_OFF;
         end else begin
            pair_lvl_ff[k] <= dec_level[k];
         end
      end
      assign pair_level[k] = pair_lvl_ff[k];
   end

   for (genvar g = 0; g < NUM_GRPS; g++) begin : g_grp
      always_ff @(posedge ref_clk) begin
         if (!rstn) begin
            pulse_lvl_ff[g] <= CUR_10MA;
         end else begin
            pulse_lvl_ff[g] <= cfg_ff[g] ? CUR_15MA : CUR_10MA;
         end
      end
      assign pulse_level[g] = pulse_lvl_ff[g];
   end

   // Pulse-mode timer. The on-time is latched at start, so a rewrite of
   // the time field mid-pulse cannot stretch or cut the running pulse.
   wcc_pulse_state_t      pst_ff, nxt_pst;
   logic [CNT_W-1:0]      cnt_ff, nxt_cnt;
   logic [TIME_W-1:0]     time_lat_ff, nxt_time_lat;
   logic                  done_ff, nxt_done;
   logic [NUM_INPUTS-1:0] drive_ff, nxt_drive;
   logic [TIME_W-1:0]     time_fld;

   assign time_fld = cfg_ff[TIME_LSB +: TIME_W];

   always_comb begin
      nxt_pst      = pst_ff;
      nxt_cnt      = cnt_ff;
      nxt_time_lat = time_lat_ff;
      nxt_done     = 1'b0;
      case (pst_ff)
         P_IDLE: begin
            if (pulse_start) begin
               nxt_pst      = P_ON;
               nxt_time_lat = time_fld;
               nxt_cnt      = CNT_W'((int'(time_fld) + 1)
                              * PULSE_UNIT_CYC_P - 1);
            end
         end
         P_ON: begin
            if (cnt_ff == '0) begin
               nxt_pst  = P_IDLE;
               nxt_done = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         default: nxt_pst = P_IDLE;
      endcase
      // Live enables let software drop an input during a pulse.
      nxt_drive = (nxt_pst == P_ON) ? nxt_en : '0;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pst_ff      <= P_IDLE;
         cnt_ff      <= '0;
         time_lat_ff <= '0;
         done_ff     <= 1'b0;
         drive_ff    <= '0;
      end else begin
         pst_ff      <= nxt_pst;
         cnt_ff      <= nxt_cnt;
         time_lat_ff <= nxt_time_lat;
         done_ff     <= nxt_done;
         drive_ff    <= nxt_drive;
      end
   end

   assign pulse_busy  = (pst_ff == P_ON);
   assign pulse_done  = done_ff;
   assign pulse_drive = drive_ff;

   // Checks.
   logic [CNT_W-1:0] on_len_ff;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         on_len_ff <= '0;
      end else begin
         on_len_ff <= pulse_busy ? on_len_ff + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   AST_SEL_RESET: assert property (
      $rose(rstn) |-> sel_ff == '0 && pair_level[0] == CUR_OFF)
      else $error("pair selectors not zero after reset");
   AST_PAIR_OFF: assert property (
      sel_ff[2:0] == CODE_OFF |=> pair_level[0] == CUR_OFF)
      else $error("pair 12/13 driven with zero code");
   AST_PAIR_HIGH: assert property (
      sel_ff[11:9] >= 3'h5 |=> pair_level[3] == CUR_15MA)
      else $error("pair 18/19 codes 5..7 not 15 mA");
   AST_SEL_READ: assert property (
      s_axi_arvalid && s_axi_arready && rd_idx == IDX_SEL
      |=> s_axi_rdata == {20'h00000, $past(sel_ff)})
      else $error("pair selector readback wrong");
   AST_CFG_RSV: assert property (
      s_axi_arvalid && s_axi_arready && rd_idx == IDX_CFG
      |=> s_axi_rdata[23:7] == 17'h00000
      && s_axi_rdata[6:0] == $past(cfg_ff))
      else $error("reserved config bits not zero");
   AST_EN_WRITE: assert property (
      wr_go && wr_idx == IDX_EN |=> $stable(sel_ff) && $stable(cfg_ff))
      else $error("enable write disturbed other fields");
   AST_ON_TIME: assert property (
      $fell(pulse_busy) |->
      int'(on_len_ff) == (int'(time_lat_ff) + 1) * PULSE_UNIT_CYC_P)
      else $error("pulse on-time length wrong");
   AST_DONE: assert property (
      $fell(pulse_busy) |-> pulse_done)
      else $error("done not flagged at pulse end");
   AST_GRP3: assert property (
      cfg_ff[3] |=> pulse_level[3] == CUR_15MA)
      else $error("group 3 pulse current wrong");
   AST_GRP2: assert property (
      !cfg_ff[2] |=> pulse_level[2] == CUR_10MA)
      else $error("group 2 pulse current wrong");
   AST_GRP1: assert property (
      cfg_ff[1] |=> pulse_level[1] == CUR_15MA)
      else $error("group 1 pulse current wrong");
   AST_GRP0: assert property (
      !cfg_ff[0] |=> pulse_level[0] == CUR_10MA)
      else $error("group 0 pulse current wrong");
   AST_DRIVE: assert property (
      1'b1 |=> (pulse_drive & ~en_ff) == '0
      && (pulse_drive == '0 || pulse_busy))
      else $error("pulse drive on disabled input");
endmodule : wcc_top

// ### testbench/wetting_current_config_bench.sv
// Self-checking bench for the wetting current configuration bank.
// Assumes wcc_top from design/ with a short pulse unit.
// AXI4-Lite traffic, reset values and the pulse on-time are all checked.
module wetting_current_config_bench;
   import wcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int UNIT = 4;
   localparam logic [7:0] A_SEL = {IDX_SEL, 2'b00};
   localparam logic [7:0] A_CFG = {IDX_CFG, 2'b00};
   localparam logic [7:0] A_EN  = {IDX_EN, 2'b00};

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   err_total++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
   end end

   typedef struct {
      logic [7:0]  a;
      logic [31:0] d;
      logic [3:0]  s;
      logic [31:0] r;
      logic [1:0]  rsp;
   } wcc_row_t;

   logic ref_clk = 1'b0, rstn = 1'b0;
   logic awvalid = 1'b0, awready, wvalid = 1'b0, wready;
   logic bvalid, bready = 1'b0, arvalid = 1'b0, arready, rvalid;
   logic rready = 1'b0, pulse_start = 1'b0, pulse_busy, pulse_done;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic [1:0]  bresp, rresp;
   logic [23:0] pulse_drive;
   wcc_current_t pulse_level [NUM_GRPS];
   wcc_current_t pair_level [NUM_PAIRS];
   int err_total = 0, comparisons = 0;
   wcc_row_t rows [8];
   wcc_current_t exp_lvl;

   always #25 ref_clk = ~ref_clk;

   wcc_top #(.PULSE_UNIT_CYC_P(UNIT)) dut (
      .ref_clk(ref_clk), .rstn(rstn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .pulse_start(pulse_start), .pulse_busy(pulse_busy),
      .pulse_done(pulse_done), .pulse_drive(pulse_drive),
      .pulse_level(pulse_level), .pair_level(pair_level));

   function automatic wcc_current_t lvl(input logic [2:0] c);
      case (c)
         3'h0: lvl = CUR_OFF;
         3'h1: lvl = CUR_1MA;
         3'h2: lvl = CUR_2MA;
         3'h3: lvl = CUR_5MA;
         3'h4: lvl = CUR_10MA;
         default: lvl = CUR_15MA;
      endcase
   endfunction : lvl

   task automatic complete_run;
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   task automatic hang;
      err_total++;
      $display("CHECK FAILED handshake expected done seen timeout");
      complete_run();
   endtask : hang

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      int n;
      logic ad, wd, ah, wh, bh;
      logic [1:0] rs;
      n = 0; ad = 0; wd = 0; bh = 0;
      @(posedge ref_clk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
      wstrb <= s; bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge ref_clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         @(posedge ref_clk);
         if (ah) begin awvalid <= 1'b0; ad = 1; end
         if (wh) begin wvalid <= 1'b0; wd = 1; end
         n++;
         if (n > 50) hang();
      end
      while (!bh) begin
         @(negedge ref_clk);
         bh = bvalid;
         rs = bresp;
         @(posedge ref_clk);
         if (bh) begin bready <= 1'b0; `CHK("bresp", er, rs) end
         n++;
         if (n > 100) hang();
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      logic ah, rh;
      logic [31:0] rv;
      logic [1:0]  rs;
      n = 0; ah = 0; rh = 0;
      @(posedge ref_clk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      while (!rh) begin
         @(negedge ref_clk);
         if (!ah) ah = arvalid && arready;
         rh = rvalid;
         rv = rdata;
         rs = rresp;
         @(posedge ref_clk);
         if (ah) arvalid <= 1'b0;
         if (rh) begin
            rready <= 1'b0;
            `CHK("rdata", ed, rv)
            `CHK("rresp", er, rs)
         end
         n++;
         if (n > 100) hang();
      end
   endtask : rd

   task automatic check_reset;
      rd(A_SEL, 32'h0, RESP_OKAY);
      rd(A_CFG, 32'h0, RESP_OKAY);
      rd(A_EN, 32'h0, RESP_OKAY);
      for (int k = 0; k < NUM_PAIRS; k++)
         `CHK("pair", CUR_OFF, pair_level[k])
      for (int g = 0; g < NUM_GRPS; g++)
         `CHK("grp", CUR_10MA, pulse_level[g])
   endtask : check_reset

   task automatic pulse_run(input logic [2:0] t, input logic [23:0] en);
      int n;
      n = 0;
      wr(A_CFG, {25'h0, t, 4'h0}, 4'hf, RESP_OKAY);
      @(posedge ref_clk);
      pulse_start <= 1'b1;
      @(posedge ref_clk);
      pulse_start <= 1'b0;
      #1;
      while (pulse_busy === 1'b1 && n < 100) begin
         n++;
         `CHK("drive", en, pulse_drive)
         @(posedge ref_clk);
         pulse_start <= (n == 2);
         #1;
      end
      if (n >= 100) hang();
      `CHK("on_cycles", (int'(t) + 1) * UNIT, n)
      `CHK("done", 1'b1, pulse_done)
      `CHK("drive_off", 24'h0, pulse_drive)
   endtask : pulse_run

   initial begin
      // Writes mix reserved bits and partial strobes to probe isolation.
      rows[0] = '{A_SEL, 32'hffff_fac8, 4'hf, 32'h0000_0ac8, RESP_OKAY};
      rows[1] = '{A_SEL, 32'h0000_0100, 4'h2, 32'h0000_01c8, RESP_OKAY};
      rows[2] = '{A_SEL, 32'h0000_01a2, 4'hf, 32'h0000_01a2, RESP_OKAY};
      rows[3] = '{A_CFG, 32'hffff_ff5a, 4'hf, 32'h0000_005a, RESP_OKAY};
      rows[4] = '{A_CFG, 32'hffff_ff00, 4'he, 32'h0000_005a, RESP_OKAY};
      rows[5] = '{A_CFG, 32'h0000_0025, 4'hf, 32'h0000_0025, RESP_OKAY};
      rows[6] = '{A_EN, 32'hffa5_c3f0, 4'hf, 32'h00a5_c3f0, RESP_OKAY};
      rows[7] = '{8'h84, 32'hffff_ffff, 4'hf, 32'h0, RESP_SLVERR};
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      check_reset();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, rows[i].s, rows[i].rsp);
         rd(rows[i].a, rows[i].r, rows[i].rsp);
         #1;
         if (rows[i].a == A_SEL)
            for (int k = 0; k < NUM_PAIRS; k++)
               `CHK("pair", lvl(rows[i].r[3*k+:3]), pair_level[k])
         if (rows[i].a == A_CFG)
            for (int g = 0; g < NUM_GRPS; g++) begin
               exp_lvl = rows[i].r[g] ? CUR_15MA : CUR_10MA;
               `CHK("grp", exp_lvl, pulse_level[g])
            end
      end
      pulse_run(3'h0, 24'ha5c3f0);
      pulse_run(3'h7, 24'ha5c3f0);
      wr(A_EN, 32'h0080_0001, 4'hf, RESP_OKAY);
      pulse_run(3'h2, 24'h800001);
      // Set every group bit so that the reset below has something to clear.
      wr(A_CFG, 32'h0000_007f, 4'hf, RESP_OKAY);
      @(posedge ref_clk);
      #1;
      for (int g = 0; g < NUM_GRPS; g++)
         `CHK("grp_hi", CUR_15MA, pulse_level[g])
      // A reset in mid-run must clear everything written above.
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      check_reset();
      complete_run();
   end
endmodule : wetting_current_config_bench
